// >>> hdl/multichannel_acq_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module multichannel_acq_sequencer
   import acq_pkg::*;
#(
   parameter int unsigned DATA_W      = DATA_BITS,
   parameter int unsigned PERIOD_CYC  = ACQ_PERIOD_CYC,
   parameter int unsigned HIGH_CYC    = HIGH_PHASE_CYC,
   parameter bit          OFFSET_CORR = 1'b1,
   parameter bit          GAIN_CORR   = 1'b0,
   parameter int unsigned GAIN_FRAC   = 8
) (
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   input  wire logic [DATA_W-1:0]    adc_data_i,
   input  wire logic                 conv_done_n_i,
   input  wire logic [15:0]          gain_i,
   output logic [CHAN_BITS-1:0]      mux_sel_o,
   output logic                      sample_o,
   output logic                      start_n_o,
   output logic                      acq_clk_o,
   output logic [CHAN_COUNT-1:0]     strobe_o,
   output logic [CHAN_COUNT*DATA_W-1:0] chan_data_o,
   output logic [DATA_W:0]           corr_data_o,
   output logic                      corr_valid_o,
   input  wire logic                 res_ready_i,
   output logic                      res_valid_o,
   output logic [DATA_W+CHAN_BITS:0] res_data_o
);
   localparam int unsigned RW      = DATA_W + 1 + CHAN_BITS;
   localparam int unsigned CNT_W   = $clog2(PERIOD_CYC + 1);
   localparam int unsigned SPAN    = (ADD_CYC > 2) ? 2 : ADD_CYC;

   // Decodes a channel number into a one-hot strobe word.
   function automatic logic [CHAN_COUNT-1:0] decode4(input logic [CHAN_BITS-1:0] ch,
                                                    input logic en);
      decode4     = '0;
      decode4[ch] = en;
   endfunction

   phase_t                phase;
   logic [CNT_W-1:0]      tick;
   logic [CHAN_BITS-1:0]  chan;
   logic                  done_meta;
   logic                  done_sync;
   logic                  done_prev;
   logic [DATA_W-1:0]     data_meta;
   logic [DATA_W-1:0]     data_sync;
   logic                  done_fall;
   logic [CHAN_COUNT-1:0] next_strobe;
   logic [DATA_W-1:0]     chan_reg [CHAN_COUNT];
   logic [DATA_W-1:0]     reg_a;
   logic [DATA_W-1:0]     reg_b_n;
   logic [DATA_W:0]       diff;
   logic [DATA_W+16:0]    scaled;
   logic [DATA_W:0]       next_corr;
   logic                  load_a;
   logic [CHAN_BITS-1:0]  a_chan;
   logic                  captured;
   logic                  ovr_pend;

   acq_stream_if #(.WIDTH(RW)) to_fifo ();

   // Converter status and data inputs cross two flip-flops before any logic reads them.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_meta <= 1'b1;
         done_sync <= 1'b1;
         done_prev <= 1'b1;
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         done_meta <= conv_done_n_i;
         done_sync <= done_meta;
         done_prev <= done_sync;
         data_meta <= adc_data_i;
         data_sync <= data_meta;
      end
   end

   // Conversion is over when the status drops low.
   assign done_fall = done_prev && !done_sync;

   // Period counter; the high phase covers settling, the low phase conversion.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick <= '0;
      end else if (tick == CNT_W'(PERIOD_CYC - 1)) begin
         tick <= '0;
      end else begin
         tick <= tick + CNT_W'(1);
      end
   end

   // Phase sequencer: sample, hold plus gate delay, start pulse, conversion.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase <= PH_SAMPLE;
      end else begin
         unique case (phase)
            PH_SAMPLE: begin
               if (tick == CNT_W'(HIGH_CYC - 1)) begin
                  phase <= PH_GATE; // Falling edge of the acquisition clock.
               end
            end
            PH_GATE: begin
               if (tick == CNT_W'(HIGH_CYC - 1 + GATE_DELAY_CYC)) begin
                  phase <= PH_START; // Start follows hold by one gate delay.
               end
            end
            PH_START: begin
               if (tick == CNT_W'(HIGH_CYC - 1 + GATE_DELAY_CYC + START_PULSE_CYC)) begin
                  phase <= PH_CONV;
               end
            end
            PH_CONV: begin
               if (tick == CNT_W'(PERIOD_CYC - 1)) begin
                  phase <= PH_SAMPLE; // Rising edge of the next period.
               end
            end
         endcase
      end
   end

   // Channel counter advances once per period and wraps to zero.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chan <= CHAN_RESET;
      end else if (tick == CNT_W'(PERIOD_CYC - 1)) begin
         chan <= chan + CHAN_BITS'(1);
      end
   end

   // Analog side controls, all from flip-flops.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mux_sel_o <= CHAN_RESET;
         sample_o  <= 1'b0;
         start_n_o <= 1'b1;
         acq_clk_o <= 1'b0;
      end else begin
         mux_sel_o <= chan;
         sample_o  <= (phase == PH_SAMPLE);
         acq_clk_o <= (phase == PH_SAMPLE);
         start_n_o <= (phase != PH_START);
      end
   end

   // Only the first completion per period is accepted, so a glitch cannot restrobe.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         captured <= 1'b0;
      end else if (phase == PH_SAMPLE) begin
         captured <= 1'b0;
      end else if (done_fall && phase == PH_CONV) begin
         captured <= 1'b1;
      end
   end

   // Decoder enabled by conversion done, addressed by the channel counter.
   always_comb begin
      next_strobe = decode4(chan, done_fall && phase == PH_CONV && !captured);
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strobe_o <= '0;
      end else begin
         strobe_o <= next_strobe;
      end
   end

   // Per-channel storage; each register only changes on its own strobe.
   genvar g;
   generate
      for (g = 0; g < CHAN_COUNT; g++) begin : g_store
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               chan_reg[g] <= '0;
            end else if (next_strobe[g]) begin
               chan_reg[g] <= data_sync;
            end
         end
      end
   endgenerate

   // The output word is a plain view of the channel flops, driven by one process.
   // Separate processes per slice would each drive one variable, which is refused.
   always_comb begin
      for (int k = 0; k < CHAN_COUNT; k++) begin
         chan_data_o[k*DATA_W +: DATA_W] = chan_reg[k];
      end
   end

   // Offset variant: ground channel held complemented in B, others loaded into A.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_b_n <= '1;
         reg_a   <= '0;
         a_chan  <= CHAN_RESET;
         load_a  <= 1'b0;
      end else begin
         load_a <= 1'b0;
         if (OFFSET_CORR && next_strobe[GROUND_CHAN]) begin
            reg_b_n <= ~data_sync;
         end
         if (|next_strobe && !next_strobe[GROUND_CHAN]) begin
            reg_a  <= data_sync;
            a_chan <= chan;
            load_a <= 1'b1;
         end
      end
   end

   // Adding the complement plus one is a two's-complement subtraction.
   always_comb begin
      if (OFFSET_CORR) begin
         diff = {1'b0, reg_a} + {1'b0, reg_b_n} + (DATA_W+1)'(1);
         diff = {~diff[DATA_W], diff[DATA_W-1:0]};
      end else begin
         diff = {1'b0, reg_a};
      end
      scaled = {{16{diff[DATA_W]}}, diff} * (DATA_W+17)'({{DATA_W+1{1'b0}}, gain_i});
      if (GAIN_CORR) begin
         next_corr = scaled[GAIN_FRAC +: DATA_W+1];
      end else begin
         next_corr = diff;
      end
   end

   // Result registered one cycle after A loads, far inside one microsecond.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         corr_data_o  <= '0;
         corr_valid_o <= 1'b0;
      end else begin
         corr_valid_o <= load_a && (SPAN != 0);
         if (load_a) begin
            corr_data_o <= next_corr;
         end
      end
   end

   // Results feed the FIFO; a full FIFO drops the newest and flags it in bit RW-1.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovr_pend <= 1'b0;
      end else if (corr_valid_o && !to_fifo.ready) begin
         ovr_pend <= 1'b1;
      end else if (corr_valid_o) begin
         ovr_pend <= 1'b0;
      end
   end

   assign to_fifo.valid = corr_valid_o;
   assign to_fifo.data  = {a_chan, corr_data_o};

   logic             fifo_valid;
   logic [RW-1:0]    fifo_data;

   acq_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_s        (to_fifo.sink),
      .out_valid_o (fifo_valid),
      .out_ready_i (res_ready_i && !(res_valid_o && !res_ready_i)),
      .out_data_o  (fifo_data)
   );

   // Output stage register so the stream pins come straight from flops.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_valid_o <= 1'b0;
         res_data_o  <= '0;
      end else if (!res_valid_o || res_ready_i) begin
         res_valid_o <= fifo_valid && res_ready_i;
         res_data_o  <= {ovr_pend, fifo_data[RW-2:0]};
      end
   end

   // Upper bit of the stream word, the top bit of the channel number, is replaced by the overrun flag above.
   logic unused_msb;
   assign unused_msb = fifo_data[RW-1];

endmodule : multichannel_acq_sequencer

`default_nettype wire

// >>> hdl/acq_pkg.sv
package acq_pkg;

   // Channel addressing.
   localparam int unsigned CHAN_BITS       = 4;
   localparam int unsigned CHAN_COUNT      = 16;
   localparam int unsigned DATA_BITS       = 12;
   localparam int unsigned FIFO_DEPTH      = 16;

   // System clock and acquisition period.
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned ACQ_HZ          = 50_000;
   localparam int unsigned ACQ_PERIOD_CYC  = CLK_HZ / ACQ_HZ;
   localparam int unsigned HIGH_PHASE_CYC  = ACQ_PERIOD_CYC / 2;
   localparam int unsigned REFRESH_US      = 320;

   // Adder settling bound, one microsecond, rounded down to cycles.
   localparam int unsigned ADD_TIME_NS     = 1000;
   localparam int unsigned ADD_CYC         = (ADD_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;

   // Start pulse width in cycles and the gate delay before it.
   localparam int unsigned START_PULSE_CYC = 2;
   localparam int unsigned GATE_DELAY_CYC  = 1;

   // Channel after reset, and the ground reference channel.
   localparam logic [3:0]  CHAN_RESET      = 4'h0;
   localparam logic [3:0]  GROUND_CHAN     = 4'hf;

   // Phase sequencer states, Gray coded along the usual path.
   typedef enum logic [1:0] {
      PH_SAMPLE = 2'b00,
      PH_GATE   = 2'b01,
      PH_START  = 2'b11,
      PH_CONV   = 2'b10
   } phase_t;

endpackage : acq_pkg

// >>> hdl/acq_stream_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries one corrected result and its channel from the sequencer to the FIFO.
interface acq_stream_if #(
   parameter int unsigned WIDTH = 20
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : acq_stream_if

`default_nettype wire

// >>> hdl/acq_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module acq_fifo #(
   parameter int unsigned WIDTH = 20,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   acq_stream_if.sink            in_s,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      level;
   logic             push;
   logic             pop;

   // Ready and valid follow the fill level so back-pressure is honest.
   assign in_s.ready  = (level != (AW+1)'(DEPTH));
   assign out_valid_o = (level != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_valid_o && out_ready_i;

   // Storage array has no reset; only the pointers define its contents.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_s.data;
      end
   end

   // Pointers and level.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         level <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : acq_fifo

`default_nettype wire

// >>> testbench/multichannel_acq_sequencer_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module multichannel_acq_sequencer_checker
   import acq_pkg::*;
#(
   parameter int unsigned DATA_W = DATA_BITS
) (
   input wire logic                        clk_i,
   input wire logic                        resetn_i,
   input wire logic [CHAN_BITS-1:0]        mux_sel_o,
   input wire logic                        sample_o,
   input wire logic                        start_n_o,
   input wire logic [CHAN_COUNT-1:0]       strobe_o,
   input wire logic [CHAN_COUNT*DATA_W-1:0] chan_data_o,
   input wire logic                        corr_valid_o
);
   // Every check belongs to the one system clock and is quiet while reset is low.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // The start request is low for exactly two cycles and then returns high.
   sequence s_start_pulse;
      !start_n_o [*2] ##1 start_n_o;
   endsequence

   // Hold comes first, then the start follows after the gate delay.
   sequence s_hold_then_start;
      !sample_o ##[1:3] $fell(start_n_o);
   endsequence

   a_strobe_onehot: assert property (
      strobe_o != '0 |-> $onehot(strobe_o))
      else $error("decoder strobe is not one-hot");
   a_strobe_selects: assert property (
      strobe_o != '0 |-> strobe_o == (CHAN_COUNT'(1) << mux_sel_o))
      else $error("strobe does not match the channel select");
   a_strobe_in_hold: assert property (
      strobe_o != '0 |-> !sample_o && start_n_o)
      else $error("strobe outside the conversion phase");
   a_sel_on_rise: assert property (
      $changed(mux_sel_o) |-> $rose(sample_o))
      else $error("channel changed away from the sample rise");
   a_sel_steps_one: assert property (
      $changed(mux_sel_o) |-> mux_sel_o == $past(mux_sel_o) + 4'h1)
      else $error("channel counter did not step by one");
   a_hold_then_start: assert property (
      $fell(sample_o) |-> s_hold_then_start)
      else $error("start did not follow hold by the gate delay");
   a_start_width: assert property (
      $fell(start_n_o) |-> s_start_pulse)
      else $error("start pulse width is not two cycles");
   a_data_held: assert property (
      $changed(chan_data_o) |-> strobe_o != '0)
      else $error("channel store changed without a strobe");
   a_corr_follows: assert property (
      strobe_o != '0 && !strobe_o[GROUND_CHAN] |-> ##1 corr_valid_o)
      else $error("corrected result missing one cycle after strobe");

   c_ground_strobe: cover property (strobe_o[GROUND_CHAN]);
endmodule : multichannel_acq_sequencer_checker

bind multichannel_acq_sequencer multichannel_acq_sequencer_checker #(.DATA_W(DATA_W)) i_chk (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .mux_sel_o(mux_sel_o),
   .sample_o(sample_o),
   .start_n_o(start_n_o),
   .strobe_o(strobe_o),
   .chan_data_o(chan_data_o),
   .corr_valid_o(corr_valid_o)
);

`default_nettype wire

// >>> testbench/adc_partner_model.sv
`timescale 1ns/10ps
`default_nettype none

module adc_partner_model (
   input  wire logic        clk_i,
   input  wire logic        start_n_i,
   input  wire logic [11:0] value_i,
   input  wire logic [3:0]  delay_i,
   output logic             conv_done_n_o,
   output logic [11:0]      adc_data_o,
   output logic [11:0]      taken_o
);
   logic       start_q;
   logic       busy;
   logic [3:0] cnt;

   // Idle as busy-free with no valid result; the data lines start at a pattern.
   initial begin
      start_q       = 1'b1;
      busy          = 1'b0;
      cnt           = 4'h0;
      conv_done_n_o = 1'b1;
      adc_data_o    = 12'h5a5;
      taken_o       = 12'h000;
   end

   // The data lines toggle while converting so a stale value never looks valid.
   always @(posedge clk_i) begin
      start_q <= start_n_i;
      if (start_q && !start_n_i) begin
         busy          <= 1'b1;
         conv_done_n_o <= 1'b1;
         cnt           <= delay_i;
         taken_o       <= value_i;
         adc_data_o    <= ~adc_data_o;
      end else if (busy && cnt == 4'h0) begin
         busy          <= 1'b0;
         conv_done_n_o <= 1'b0;
         adc_data_o    <= taken_o;
      end else if (busy) begin
         cnt        <= cnt - 4'h1;
         adc_data_o <= ~adc_data_o;
      end
   end
endmodule : adc_partner_model

`default_nettype wire

// >>> testbench/test_multichannel_acq_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module test_multichannel_acq_sequencer
   import acq_pkg::*;
;
   // A short period keeps the run brief; the high half lets the hold settle.
   localparam int PER     = 40;
   localparam int HIGH    = 20;
   localparam int RUN_CYC = 62 * PER;

   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        stall = 1'b1;
   logic        res_ready = 1'b0;
   logic [11:0] conv_value = 12'h000;
   logic [3:0]  conv_delay = 4'h0;
   logic [15:0] gain = 16'h0100;
   logic [31:0] rng = 32'h0000004a;
   wire  logic        conv_done_n;
   wire  logic [11:0] adc_data;
   wire  logic [11:0] adc_taken;
   wire  logic [3:0]  mux_sel_o;
   wire  logic        start_n_o;
   wire  logic [15:0] strobe_o;
   wire  logic [191:0] chan_data_o;
   wire  logic [12:0] corr_data_o;
   wire  logic        corr_valid_o;
   wire  logic        sample_o;
   wire  logic        acq_clk;
   wire  logic        res_valid;
   wire  logic [16:0] res_data;
   logic [15:0] exp_q [$];
   int a_ch = 0;
   int n_errors = 0;
   int comparisons = 0;
   int exp_ch = 0;
   int ground = 0;
   int exp_corr = 0;
   int n_strobe = 0;
   bit gnd_ok = 1'b0;
   bit corr_due = 1'b0;

   always #5 clk_i = ~clk_i;

   multichannel_acq_sequencer #(.PERIOD_CYC(PER), .HIGH_CYC(HIGH)) i_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .adc_data_i(adc_data),
      .conv_done_n_i(conv_done_n), .gain_i(gain), .mux_sel_o(mux_sel_o),
      .sample_o(sample_o), .start_n_o(start_n_o), .acq_clk_o(acq_clk), .strobe_o(strobe_o),
      .chan_data_o(chan_data_o), .corr_data_o(corr_data_o), .corr_valid_o(corr_valid_o),
      .res_ready_i(res_ready), .res_valid_o(res_valid), .res_data_o(res_data));

   // The converter finishes within the low half of each period.
   adc_partner_model i_adc (
      .clk_i(clk_i), .start_n_i(start_n_o), .value_i(conv_value), .delay_i(conv_delay),
      .conv_done_n_o(conv_done_n), .adc_data_o(adc_data), .taken_o(adc_taken));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic judge(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_sel(input logic [15:0] got, input logic [15:0] exp);
      judge(got, exp);
   endtask

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      judge(got, exp);
   endtask

   task automatic tally_and_finish;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Fresh random stimulus each cycle; delays range from prompt to slow.
   always @(posedge clk_i) begin
      rng        <= xs(rng);
      conv_value <= rng[11:0];
      conv_delay <= {1'b0, rng[14:12]};
      gain       <= rng[31:16];
      res_ready  <= stall ? 1'b0 : rng[15];
   end

   // Reference model, sampled mid-cycle so every registered output has settled.
   always @(negedge clk_i) begin
      if (resetn_i && strobe_o !== 16'h0) begin
         cmp_sel(strobe_o, 16'h1 << exp_ch);
         cmp_sel({12'h0, mux_sel_o}, 16'(exp_ch));
         cmp_word({4'h0, chan_data_o[exp_ch*12 +: 12]}, {4'h0, adc_taken});
         cmp_sel({15'h0, acq_clk}, 16'h0000);
         a_ch = exp_ch;
         if (exp_ch == 15) begin
            ground   = int'(adc_taken);
            gnd_ok   = 1'b1;
            corr_due = 1'b0;
         end else begin
            exp_corr = (int'(adc_taken) - ground) & 'h1fff;
            corr_due = gnd_ok;
         end
         exp_ch = (exp_ch + 1) % 16;
         n_strobe++;
      end
      // Queue model of buffer plus output stage; a word finding the buffer full is lost.
      if (resetn_i && corr_valid_o === 1'b1) begin
         if (exp_q.size() - int'(res_valid) < 16)
            exp_q.push_back(16'({a_ch[2:0], exp_corr[12:0]}));
      end
      if (resetn_i && res_valid === 1'b1 && res_ready === 1'b1) begin
         cmp_word(res_data[15:0], (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff);
      end
      if (resetn_i && corr_valid_o === 1'b1 && corr_due) begin
         cmp_word(16'(corr_data_o), 16'(exp_corr));
         corr_due = 1'b0;
      end
   end

   // A hang must still reach the verdict, so the watchdog shares the closing task.
   initial begin
      repeat (RUN_CYC + 200) @(posedge clk_i);
      n_errors++;
      tally_and_finish();
   end

   // Stall the consumer to fill the buffer, drain it, reset mid-conversion, run again.
   initial begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (20 * PER) @(posedge clk_i);
      stall <= 1'b0;
      repeat (4 * PER + HIGH + 4) @(posedge clk_i);
      resetn_i <= 1'b0;
      exp_ch   = 0;
      gnd_ok   = 1'b0;
      corr_due = 1'b0;
      n_strobe = 0;
      ground   = 0;
      exp_q.delete();
      @(negedge clk_i);
      for (int g = 0; g < 16; g++) begin
         cmp_word({4'h0, chan_data_o[g*12 +: 12]}, 16'h0000);
      end
      @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (34 * PER) @(posedge clk_i);
      cmp_word(16'(n_strobe), 16'd34);
      tally_and_finish();
   end
endmodule : test_multichannel_acq_sequencer

`default_nettype wire
